// >>> src/sip_consts.vh
// Constants for the switch ingress priority, VLAN and spanning-tree block
// Behaviour
// - Egress queue comes from one chosen priority source of five.
// - Non-static sources pass through the traffic class table.
// - Static address-table value is the queue number directly.
// - Port default priority is held with the port default VLAN id entry.
// - Precedence priority is the top three bits of the IPv4 TOS byte.
// - DiffServ table indexed by top six bits of TOS or traffic class.
// - DiffServ table is not initialised by reset.
// - Tag priority is remapped through a per-port regeneration table.
// - VLAN table holds 16 entries of id, membership and untag set.
// - Tagged id other than 000h or FFFh is searched; a hit applies.
// - A miss gives empty membership; filtered when ingress checking is on.
// - Empty membership with unknown destination is filtered.
// - Untagged or id 0 frames take the port default id; untagged ones also its priority.
// - Membership drives ingress, egress checks and flood confinement.
// - Untag set applies only on hybrid egress ports.
// - Two-bit port state: 01 blocking, 11 listening, 10 learning, 00 fwd.
// - Blocking or listening: drop receive, block transmit, no learning.
// - Learning: drop receive, block transmit, learning on.
// - Forwarding: receive, transmit and learning all normal.
// - Static plus age destination entries bypass port state.
// - Tagged id FFFh is filtered while VLAN support is on.
`ifndef SIP_CONSTS_VH
`define SIP_CONSTS_VH
// Register byte offsets
`define SIP_GCFG_OFS   8'h00
`define SIP_TCLS_OFS   8'h04
`define SIP_REGEN0_OFS 8'h08
`define SIP_REGEN1_OFS 8'h0c
`define SIP_REGEN2_OFS 8'h10
`define SIP_STP_OFS    8'h14
`define SIP_DSCMD_OFS  8'h18
`define SIP_DSWR_OFS   8'h1c
`define SIP_DSRD_OFS   8'h20
`define SIP_DSSTS_OFS  8'h24
`define SIP_VCMD_OFS   8'h28
`define SIP_VWR_OFS    8'h2c
`define SIP_VRD_OFS    8'h30
`define SIP_VSTS_OFS   8'h34
`define SIP_HYB_OFS    8'h38
// Global config bits
`define SIP_G_VLAN_EN  0
`define SIP_G_DA_PRIO  1
`define SIP_G_USE_TAG  2
`define SIP_G_USE_IP   3
`define SIP_G_DS_EN    4
`define SIP_G_MCHK     5
// Command fields
`define SIP_DS_WR_BIT  6
`define SIP_DS_RD_BIT  7
`define SIP_V_WR_BIT   5
`define SIP_V_RD_BIT   6
`define SIP_V_PDEF_BIT 4
// VLAN entry layout
`define SIP_E_MEM_LSB  12
`define SIP_E_UNT_LSB  15
`define SIP_E_VAL_BIT  18
`define SIP_E_PRIO_LSB 12
// Port states and special ids
`define SIP_ST_BLOCK   2'b01
`define SIP_ST_LISTEN  2'b11
`define SIP_ST_LEARN   2'b10
`define SIP_ST_FWD     2'b00
`define SIP_VID_NULL   12'h000
`define SIP_VID_RSVD   12'hfff
// Reset values
`define SIP_TCLS_RST   16'hfa50
`define SIP_REGEN_RST  24'hfac688
`endif

// >>> src/sip_ingress.v
// Ingress priority, VLAN resolution and spanning-tree gating with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "sip_consts.vh"

module sip_ingress #(
   parameter NV = 16,
   parameter NP = 3
) (
   // APB
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Classification request from frame parser
   input  wire        cls_req,
   input  wire [1:0]  cls_port,
   input  wire        cls_tagged,
   input  wire [11:0] cls_vid,
   input  wire [2:0]  cls_pcp,
   input  wire        cls_ipv4,
   input  wire        cls_ipv6,
   input  wire [7:0]  cls_tos,
   // Address table lookup result
   input  wire        da_found,
   input  wire        da_static,
   input  wire        da_age,
   input  wire [1:0]  da_queue,
   input  wire [2:0]  da_ports,
   // Classification result
   output reg         res_valid,
   output reg  [1:0]  res_queue,
   output reg  [11:0] res_vid,
   output reg  [2:0]  res_member,
   output reg  [2:0]  res_untag,
   output reg  [2:0]  res_ports,
   output reg         res_drop,
   output reg         res_learn,
   // Per-port state for transmit and learning logic
   output reg  [2:0]  tx_allow,
   output reg  [2:0]  learn_allow
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function st_fwd;
      input [1:0] st;
      st_fwd = (st == `SIP_ST_FWD);
   endfunction

   function st_learn;
      input [1:0] st;
      st_learn = (st == `SIP_ST_FWD) || (st == `SIP_ST_LEARN);
   endfunction

   // ------------------------------------------------------------
   // Registers and tables
   // ------------------------------------------------------------
   reg  [5:0]  gcfg_r;
   reg  [15:0] tcls_r;
   reg  [23:0] regen_r [0:NP-1];
   reg  [5:0]  stp_r;
   reg  [7:0]  dscmd_r;
   reg  [2:0]  dswr_r;
   reg  [2:0]  dsrd_r;
   reg  [6:0]  vcmd_r;
   reg  [18:0] vwr_r;
   reg  [18:0] vrd_r;
   reg  [2:0]  hyb_r;
   reg  [18:0] vtab_r [0:NV-1];
   reg  [14:0] pdvid_r [0:NP-1];
   // No reset on purpose: contents stay undefined until the host loads them
   reg  [2:0]  ds_mem [0:63];

   wire        acc   = psel & penable & pready;
   wire        wr_en = acc & pwrite;
   reg  [31:0] rd_nxt;
   reg         map_nxt;
   integer     i;

   always @* begin
      rd_nxt  = 32'h0;
      map_nxt = 1'b1;
      case (paddr)
         `SIP_GCFG_OFS:   rd_nxt = {26'h0, gcfg_r};
         `SIP_TCLS_OFS:   rd_nxt = {16'h0, tcls_r};
         `SIP_REGEN0_OFS: rd_nxt = {8'h0, regen_r[0]};
         `SIP_REGEN1_OFS: rd_nxt = {8'h0, regen_r[1]};
         `SIP_REGEN2_OFS: rd_nxt = {8'h0, regen_r[2]};
         `SIP_STP_OFS:    rd_nxt = {26'h0, stp_r};
         `SIP_DSCMD_OFS:  rd_nxt = {24'h0, dscmd_r};
         `SIP_DSWR_OFS:   rd_nxt = {29'h0, dswr_r};
         `SIP_DSRD_OFS:   rd_nxt = {29'h0, dsrd_r};
         `SIP_DSSTS_OFS:  rd_nxt = 32'h0;
         `SIP_VCMD_OFS:   rd_nxt = {25'h0, vcmd_r};
         `SIP_VWR_OFS:    rd_nxt = {13'h0, vwr_r};
         `SIP_VRD_OFS:    rd_nxt = {13'h0, vrd_r};
         `SIP_VSTS_OFS:   rd_nxt = 32'h0;
         `SIP_HYB_OFS:    rd_nxt = {29'h0, hyb_r};
         default:         map_nxt = 1'b0;
      endcase
   end

   // One wait state: pready rises in the second access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & penable & ~pready;
         prdata  <= (psel & penable & ~pready & ~pwrite) ? rd_nxt : 32'h0;
         pslverr <= psel & penable & ~pready & ~map_nxt;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gcfg_r  <= 6'h0;
         tcls_r  <= `SIP_TCLS_RST;
         stp_r   <= 6'h0;
         dscmd_r <= 8'h0;
         dswr_r  <= 3'h0;
         dsrd_r  <= 3'h0;
         vcmd_r  <= 7'h0;
         vwr_r   <= 19'h0;
         vrd_r   <= 19'h0;
         hyb_r   <= 3'h0;
         for (i = 0; i < NP; i = i + 1) begin
            regen_r[i] <= `SIP_REGEN_RST;
            pdvid_r[i] <= 15'h0001;
         end
         for (i = 0; i < NV; i = i + 1)
            vtab_r[i] <= 19'h0;
      end else if (wr_en) begin
         case (paddr)
            `SIP_GCFG_OFS:   gcfg_r     <= pwdata[5:0];
            `SIP_TCLS_OFS:   tcls_r     <= pwdata[15:0];
            `SIP_REGEN0_OFS: regen_r[0] <= pwdata[23:0];
            `SIP_REGEN1_OFS: regen_r[1] <= pwdata[23:0];
            `SIP_REGEN2_OFS: regen_r[2] <= pwdata[23:0];
            `SIP_STP_OFS:    stp_r      <= pwdata[5:0];
            `SIP_DSWR_OFS:   dswr_r     <= pwdata[2:0];
            `SIP_HYB_OFS:    hyb_r      <= pwdata[2:0];
            `SIP_VWR_OFS:    vwr_r      <= pwdata[18:0];
            `SIP_DSCMD_OFS: begin
               dscmd_r <= pwdata[7:0];
               if (pwdata[`SIP_DS_RD_BIT])
                  dsrd_r <= ds_mem[pwdata[5:0]];
            end
            `SIP_VCMD_OFS: begin
               vcmd_r <= pwdata[6:0];
               if (pwdata[`SIP_V_WR_BIT]) begin
                  if (pwdata[`SIP_V_PDEF_BIT])
                     pdvid_r[pwdata[1:0]] <= vwr_r[14:0];
                  else
                     vtab_r[pwdata[3:0]] <= vwr_r;
               end
               if (pwdata[`SIP_V_RD_BIT]) begin
                  if (pwdata[`SIP_V_PDEF_BIT])
                     vrd_r <= {4'h0, pdvid_r[pwdata[1:0]]};
                  else
                     vrd_r <= vtab_r[pwdata[3:0]];
               end
            end
            default: ;
         endcase
      end
   end

   always @(posedge pclk) begin
      if (wr_en && paddr == `SIP_DSCMD_OFS && pwdata[`SIP_DS_WR_BIT])
         ds_mem[pwdata[5:0]] <= dswr_r;
   end

   // ------------------------------------------------------------
   // Priority selection
   // ------------------------------------------------------------
   wire [14:0] pv_ent  = pdvid_r[cls_port];
   wire [2:0]  pdef    = pv_ent[`SIP_E_PRIO_LSB+2:`SIP_E_PRIO_LSB];
   wire [23:0] rg_ent  = regen_r[cls_port];
   wire [2:0]  rg_prio = rg_ent[cls_pcp*3 +: 3];
   wire [2:0]  ds_prio = ds_mem[cls_tos[7:2]];
   wire        da_sel  = gcfg_r[`SIP_G_DA_PRIO] & da_found & da_static;
   reg  [2:0]  prio;
   reg  [1:0]  queue;

   always @* begin
      if (gcfg_r[`SIP_G_USE_IP] & gcfg_r[`SIP_G_DS_EN] & (cls_ipv4 | cls_ipv6))
         prio = ds_prio;
      else if (gcfg_r[`SIP_G_USE_IP] & ~gcfg_r[`SIP_G_DS_EN] & cls_ipv4)
         prio = cls_tos[7:5];
      else if (gcfg_r[`SIP_G_USE_TAG] & cls_tagged)
         prio = rg_prio;
      else
         prio = pdef;
      if (da_sel)
         queue = da_queue;
      else
         queue = tcls_r[prio*2 +: 2];
   end

   // ------------------------------------------------------------
   // VLAN resolution
   // ------------------------------------------------------------
   wire        use_pv  = ~cls_tagged | (cls_vid == `SIP_VID_NULL);
   wire [11:0] eff_vid = use_pv ? pv_ent[11:0] : cls_vid;
   wire        vid_bad = cls_tagged & (cls_vid == `SIP_VID_RSVD);
   reg         hit;
   reg  [2:0]  mem_t;
   reg  [2:0]  unt_t;

   always @* begin
      hit   = 1'b0;
      mem_t = 3'h0;
      unt_t = 3'h0;
      for (i = 0; i < NV; i = i + 1) begin
         if (!hit && vtab_r[i][`SIP_E_VAL_BIT] && vtab_r[i][11:0] == eff_vid) begin
            hit   = 1'b1;
            mem_t = vtab_r[i][`SIP_E_MEM_LSB+2:`SIP_E_MEM_LSB];
            unt_t = vtab_r[i][`SIP_E_UNT_LSB+2:`SIP_E_UNT_LSB];
         end
      end
   end

   wire       vlan_on = gcfg_r[`SIP_G_VLAN_EN];
   // A miss leaves membership empty while VLAN support is on
   wire [2:0] member  = vlan_on ? mem_t : 3'b111;
   wire [2:0] src_b   = 3'b001 << cls_port;
   wire       ovr     = da_found & da_static & da_age;
   wire       mchk    = vlan_on & gcfg_r[`SIP_G_MCHK];

   // ------------------------------------------------------------
   // Per-port spanning-tree gating
   // ------------------------------------------------------------
   wire [NP-1:0] p_fwd;
   wire [NP-1:0] p_lrn;
   wire [NP-1:0] dst_c;
   wire [2:0]    cand = da_found ? da_ports : member;

   genvar g;
   generate
      for (g = 0; g < NP; g = g + 1) begin : g_port
         assign p_fwd[g] = st_fwd(stp_r[2*g +: 2]);
         assign p_lrn[g] = st_learn(stp_r[2*g +: 2]);
         assign dst_c[g] = cand[g] & ~src_b[g] & (~mchk | member[g])
                           & (p_fwd[g] | ovr);
      end
   endgenerate

   wire src_fwd = |(p_fwd & src_b);
   wire drop_c  = (vlan_on & vid_bad)
                | (mchk & ~|(member & src_b))
                | (vlan_on & ~da_found & ~|member)
                | (~src_fwd & ~ovr)
                | ~|dst_c;

   // ------------------------------------------------------------
   // Result registers
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res_valid   <= 1'b0;
         res_queue   <= 2'h0;
         res_vid     <= 12'h0;
         res_member  <= 3'h0;
         res_untag   <= 3'h0;
         res_ports   <= 3'h0;
         res_drop    <= 1'b0;
         res_learn   <= 1'b0;
         tx_allow    <= 3'h0;
         learn_allow <= 3'h0;
      end else begin
         tx_allow    <= p_fwd;
         learn_allow <= p_lrn;
         res_valid   <= cls_req;
         if (cls_req) begin
            res_queue  <= queue;
            res_vid    <= eff_vid;
            res_member <= member;
            res_untag  <= vlan_on ? (unt_t & hyb_r) : 3'h0;
            res_ports  <= drop_c ? 3'h0 : dst_c;
            res_drop   <= drop_c;
            res_learn  <= |(p_lrn & src_b);
         end
      end
   end

endmodule // sip_ingress
`default_nettype wire

// >>> verification/sip_ingress_properties.sv
// Port-level properties of the ingress classifier
`timescale 1ns/1ps
`default_nettype none
module sip_ingress_properties (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Classification
   input wire logic        cls_req,
   input wire logic [1:0]  cls_port,
   input wire logic        da_found,
   input wire logic        da_static,
   input wire logic        da_age,
   input wire logic        res_valid,
   input wire logic [2:0]  res_ports,
   input wire logic        res_drop,
   input wire logic        res_learn,
   input wire logic [2:0]  tx_allow,
   input wire logic [2:0]  learn_allow
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Static plus age entry lets a frame past the port state
   wire ovr = da_found && da_static && da_age;
   sequence s_access;
      psel && penable && !$past(penable);
   endsequence
   sequence s_one_wait;
      !pready ##1 pready;
   endsequence
   a_ready_wait: assert property (s_access |-> s_one_wait) else $error("pready timing off");
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
   a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
   a_idle_rdata: assert property (!pready |-> prdata == 32'h0) else $error("prdata idle");
   a_res_latency: assert property (cls_req |=> res_valid) else $error("res_valid late");
   a_res_quiet: assert property (!cls_req |=> !res_valid) else $error("res_valid spurious");
   a_tx_in_learn: assert property ((tx_allow & ~learn_allow) == 3'b000) else $error("tx");
   a_src_learn: assert property (cls_req |=> res_learn == $past(learn_allow[cls_port]))
      else $error("res_learn wrong");
   a_src_block: assert property (cls_req && !tx_allow[cls_port] && !ovr |=> res_drop)
      else $error("blocked source passed");
   a_dst_block: assert property (cls_req && !ovr |=> res_drop ||
      (res_ports & ~$past(tx_allow)) == 3'b000) else $error("blocked dest used");
   a_no_ports: assert property (res_valid && !res_drop |-> res_ports != 3'b000)
      else $error("passed with no ports");
   a_src_excluded: assert property (cls_req |=> res_drop || !res_ports[$past(cls_port)])
      else $error("source in dest");
endmodule // sip_ingress_properties
`default_nettype wire

// >>> verification/sip_rx_model.sv
// Frame parser and address lookup model feeding classification requests
`timescale 1ns/1ps
`default_nettype none
module sip_rx_model (
   // Clock
   input  wire logic        pclk,
   // Frame descriptor and lookup result
   output var  logic        req,
   output var  logic [35:0] fr
);
   initial begin
      req = 1'b0;
      fr  = 36'h0;
   end
   // Fields are inverted after each request so stale values never look current
   task automatic send(input logic [35:0] v);
      @(posedge pclk);
      req <= 1'b1;
      fr  <= v;
      @(posedge pclk);
      req <= 1'b0;
      fr  <= ~v;
   endtask
endmodule // sip_rx_model
`default_nettype wire

// >>> verification/sip_ingress_bench.sv
// Self-checking bench for the ingress classifier
`timescale 1ns/1ps
`default_nettype none
`include "sip_consts.vh"
module sip_ingress_bench;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] rdat;
   logic        rerr;
   logic [1:0]  st;
   logic        fw;
   logic        ln;
   logic [1:0]  sts [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
   int          error_cnt = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   int          i;
   wire  [31:0] prdata;
   wire         pready, pslverr, req, res_valid, res_drop, res_learn;
   wire  [35:0] fr;
   wire  [1:0]  res_queue;
   wire  [11:0] res_vid;
   wire  [2:0]  res_member, res_untag, res_ports, tx_allow, learn_allow;
   localparam logic [15:0] TC = 16'h39e4;
   sip_rx_model rx (.pclk, .req, .fr);
   sip_ingress DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .cls_req(req), .cls_port(fr[35:34]), .cls_tagged(fr[33]),
      .cls_vid(fr[32:21]), .cls_pcp(fr[20:18]), .cls_ipv4(fr[17]), .cls_ipv6(fr[16]),
      .cls_tos(fr[15:8]), .da_found(fr[7]), .da_static(fr[6]), .da_age(fr[5]),
      .da_queue(fr[4:3]), .da_ports(fr[2:0]), .res_valid, .res_queue, .res_vid,
      .res_member, .res_untag, .res_ports, .res_drop, .res_learn, .tx_allow, .learn_allow);
   always #10 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         error_cnt++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat    = prdata;
      rerr    = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask
   // Descriptor da is {found, static, age, queue[1:0], ports[2:0]}
   task automatic frm(input logic [1:0] p, input logic t, input logic [11:0] vid,
      input logic [2:0] pcp, input logic [1:0] ip, input logic [7:0] tos, input logic [7:0] da);
      rx.send({p, t, vid, pcp, ip, tos, da});
      #1;
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc(`SIP_TCLS_OFS, 32'hfa50);
      rdc(`SIP_REGEN1_OFS, 32'hfac688);
      rdc(`SIP_STP_OFS, 32'h0);
      wr(8'h3c, 32'hffffffff);
      rdc(8'h3c, 32'h0);
      chk(rerr, 32'h1);
      chk(tx_allow, 32'h7);
      wr(`SIP_TCLS_OFS, TC);
      for (i = 0; i < 8; i++) begin
         wr(`SIP_VWR_OFS, (i << 12) | 1);
         wr(`SIP_VCMD_OFS, 32'h31);
         frm(2'd1, 1'b0, 12'h0, 3'd0, 2'b00, 8'h00, 8'h00);
         chk(res_queue, (TC >> 2 * i) & 3);
      end
      chk(res_vid, 32'h1);
      chk(res_ports, 32'h5);
      wr(`SIP_GCFG_OFS, 32'h8);
      frm(2'd1, 1'b1, 12'h005, 3'd0, 2'b10, 8'ha0, 8'h00);
      chk(res_queue, (TC >> 10) & 3);
      frm(2'd1, 1'b0, 12'h0, 3'd0, 2'b10, 8'h5c, 8'h00);
      chk(res_queue, (TC >> 4) & 3);
      frm(2'd1, 1'b0, 12'h0, 3'd0, 2'b01, 8'h5c, 8'h00);
      chk(res_queue, (TC >> 14) & 3);
      for (i = 0; i < 64; i++) begin
         wr(`SIP_DSWR_OFS, (i & 7) ^ 5);
         wr(`SIP_DSCMD_OFS, 64 | i);
      end
      wr(`SIP_DSCMD_OFS, 128 | 46);
      rdc(`SIP_DSRD_OFS, 32'h3);
      wr(`SIP_GCFG_OFS, 32'h18);
      frm(2'd1, 1'b0, 12'h0, 3'd0, 2'b01, 8'hb4, 8'h00);
      chk(res_queue, TC & 3);
      frm(2'd0, 1'b0, 12'h0, 3'd0, 2'b10, 8'h7b, 8'h00);
      chk(res_queue, (TC >> 6) & 3);
      wr(`SIP_GCFG_OFS, 32'h4);
      wr(`SIP_REGEN1_OFS, 32'h053977);
      frm(2'd1, 1'b1, 12'h005, 3'd2, 2'b00, 8'h00, 8'h00);
      chk(res_queue, (TC >> 10) & 3);
      frm(2'd0, 1'b1, 12'h005, 3'd6, 2'b00, 8'h00, 8'h00);
      chk(res_queue, (TC >> 12) & 3);
      wr(`SIP_GCFG_OFS, 32'h6);
      frm(2'd1, 1'b1, 12'h005, 3'd2, 2'b00, 8'h00, 8'hd9);
      chk(res_queue, 32'h3);
      wr(`SIP_VWR_OFS, 32'h53123);
      wr(`SIP_VCMD_OFS, 32'h20);
      wr(`SIP_VWR_OFS, 32'h46456);
      wr(`SIP_VCMD_OFS, 32'h2f);
      wr(`SIP_VWR_OFS, 32'h456);
      wr(`SIP_VCMD_OFS, 32'h31);
      wr(`SIP_HYB_OFS, 32'h4);
      wr(`SIP_GCFG_OFS, 32'h21);
      frm(2'd0, 1'b1, 12'h123, 3'd0, 2'b00, 8'h00, 8'h00);
      chk({res_drop, res_member, res_ports, res_untag}, 32'h0d0);
      wr(`SIP_HYB_OFS, 32'h2);
      frm(2'd0, 1'b1, 12'h123, 3'd0, 2'b00, 8'h00, 8'h00);
      chk(res_untag, 32'h2);
      frm(2'd1, 1'b0, 12'h0, 3'd0, 2'b00, 8'h00, 8'h00);
      chk({res_vid, res_member, res_ports}, 32'h115b4);
      frm(2'd1, 1'b1, 12'h000, 3'd0, 2'b00, 8'h00, 8'h00);
      chk(res_vid, 32'h456);
      frm(2'd0, 1'b1, 12'h789, 3'd0, 2'b00, 8'h00, 8'h00);
      chk({res_drop, res_member}, 32'h8);
      frm(2'd0, 1'b1, 12'hfff, 3'd0, 2'b00, 8'h00, 8'h00);
      chk(res_drop, 32'h1);
      frm(2'd2, 1'b1, 12'h123, 3'd0, 2'b00, 8'h00, 8'h00);
      chk(res_drop, 32'h1);
      wr(`SIP_GCFG_OFS, 32'h1);
      frm(2'd0, 1'b1, 12'h789, 3'd0, 2'b00, 8'h00, 8'h00);
      chk(res_drop, 32'h1);
      frm(2'd0, 1'b1, 12'h789, 3'd0, 2'b00, 8'h00, 8'h84);
      chk({res_drop, res_ports}, 32'h4);
      wr(`SIP_GCFG_OFS, 32'h0);
      for (i = 0; i < 4; i++) begin
         st = sts[i];
         fw = (st == `SIP_ST_FWD);
         ln = fw || (st == `SIP_ST_LEARN);
         wr(`SIP_STP_OFS, st << 2);
         frm(2'd1, 1'b0, 12'h0, 3'd0, 2'b00, 8'h00, 8'h00);
         chk({tx_allow, learn_allow}, {1'b1, fw, 1'b1, 1'b1, ln, 1'b1});
         chk({res_drop, res_learn}, {!fw, ln});
         frm(2'd0, 1'b0, 12'h0, 3'd0, 2'b00, 8'h00, 8'h00);
         chk(res_ports, {1'b1, fw, 1'b0});
         frm(2'd1, 1'b0, 12'h0, 3'd0, 2'b00, 8'h00, 8'he1);
         chk({res_drop, res_ports}, 32'h1);
      end
      test_done();
   end
endmodule // sip_ingress_bench
bind sip_ingress sip_ingress_properties u_props (.pclk, .presetn, .psel, .penable, .prdata,
   .pready, .pslverr, .cls_req, .cls_port, .da_found, .da_static, .da_age, .res_valid,
   .res_ports, .res_drop, .res_learn, .tx_allow, .learn_allow);
`default_nettype wire
